// ### core/lfwk_correlator.sv
// Wake-up pattern correlator: preamble search, pattern match, wake and timeout.
// Assumes rtc_clk_pin, lf_data and freq_detect are asynchronous to core_clk;
// configuration inputs and terminate_wake come from core_clk logic.
`timescale 1ns/10ps
`include "lfwk_cfg.svh"
module lfwk_correlator
    import lfwk_pkg::*;
#(
    parameter int unsigned TIMEOUT_STEP_CYCLES = `LFWK_TIMEOUT_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic rtc_clk_pin,
    input wire logic lf_data,
    input wire logic freq_detect,
    input wire logic terminate_wake,
    input wire logic correlator_enable_bit,
    input wire logic double_pattern_select,
    input wire logic [1:0] missed_zero_tolerance,
    input wire logic [7:0] wake_pattern_high_byte,
    input wire logic [7:0] wake_pattern_low_byte,
    input wire logic [7:0] bit_period_and_timeout,
    output logic wake,
    output logic listening,
    output logic [7:0] false_wakeup_count
);
    localparam logic [6:0] PRE_WAIT_HALVES = 7'(2 * `LFWK_PRE_WAIT_BITS);
    localparam logic [3:0] PRE_MIN_HALVES = 4'(2 * `LFWK_PRE_MIN_BITS);
    localparam logic [6:0] FRAME_MAX_HALVES = 7'(2 * `LFWK_FRAME_MAX_BITS);
    localparam logic [3:0] PAT_LAST = 4'(`LFWK_PATTERN_HALVES - 1);

    function automatic logic [4:0] zero_misses(input lfwk_halves_t rx, input lfwk_halves_t pat);
        logic [4:0] n;
        lfwk_halves_t miss;
        n = 5'h00;
        miss = rx & ~pat;
        for (int i = 0; i < 16; i++) begin
            n = n + {4'h0, miss[i]};
        end
        return n;
    endfunction

    // Expected carrier-on halves must be present; gaps may be missed up to tol
    function automatic logic pattern_ok(input lfwk_halves_t rx, input lfwk_halves_t pat,
                                        input logic [1:0] tol);
        return ((pat & ~rx) == 16'h0000) && (zero_misses(rx, pat) <= {3'b000, tol});
    endfunction

    // Synchronisers
    logic rtc_s1, rtc_s2, rtc_s3;
    logic dat_s1, dat_s2, dat_s3;
    logic fd_s1, fd_s2, fd_s3;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rtc_s1 <= 1'b0;
            rtc_s2 <= 1'b0;
            rtc_s3 <= 1'b0;
            dat_s1 <= 1'b0;
            dat_s2 <= 1'b0;
            dat_s3 <= 1'b0;
            fd_s1 <= 1'b0;
            fd_s2 <= 1'b0;
            fd_s3 <= 1'b0;
        end else begin
            rtc_s1 <= rtc_clk_pin;
            rtc_s2 <= rtc_s1;
            rtc_s3 <= rtc_s2;
            dat_s1 <= lf_data;
            dat_s2 <= dat_s1;
            dat_s3 <= dat_s2;
            fd_s1 <= freq_detect;
            fd_s2 <= fd_s1;
            fd_s3 <= fd_s2;
        end
    end

    logic rtc_tick;
    logic dat_edge;
    logic fd_rise;
    assign rtc_tick = rtc_s2 & ~rtc_s3;
    assign dat_edge = dat_s2 ^ dat_s3;
    assign fd_rise = fd_s2 & ~fd_s3;

    lfwk_state_e state;
    lfwk_state_e next_state;
    logic half_stb;
    logic timer_run;
    lfwk_code_t bit_field;
    lfwk_code_t bit_code;
    logic [2:0] tout_code;
    lfwk_halves_t pattern;
    lfwk_halves_t next_rx;
    lfwk_halves_t rx_sh;
    logic sample;
    logic prev_half;
    logic [3:0] pre_run;
    logic [6:0] half_cnt;
    logic [3:0] sec_cnt;
    logic dly_cnt;
    logic [31:0] step_cnt;
    logic [2:0] to_steps;
    logic to_expire;
    logic fail;
    logic half_chg;

    assign bit_field = bit_period_and_timeout[`LFWK_BITP_MSB:`LFWK_BITP_LSB];
    // First strobe of an attempt has no earlier half to change from
    assign half_chg = (sample != prev_half) && (half_cnt != 7'h00);
    // Codes below the first legal one run at the shortest period
    assign bit_code = (bit_field < `LFWK_BIT_CODE_MIN) ? `LFWK_BIT_CODE_MIN : bit_field;
    assign tout_code = bit_period_and_timeout[`LFWK_TOUT_MSB:`LFWK_TOUT_LSB];
    assign pattern = {wake_pattern_high_byte, wake_pattern_low_byte};
    assign sample = dat_s2;
    assign next_rx = {rx_sh[14:0], sample};
    assign timer_run = (state == LFWK_PREAMBLE) || (state == LFWK_PATTERN) ||
                       (state == LFWK_PATTERN2) || (state == LFWK_WAKE_DLY);
    assign to_expire = (tout_code != 3'b000) && (to_steps == tout_code);

    lfwk_bit_timer u_bit_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(timer_run),
        .rtc_tick(rtc_tick),
        .resync(dat_edge && timer_run),
        .bit_code(bit_code),
        .half_stb(half_stb)
    );

    always_comb begin
        next_state = state;
        fail = 1'b0;
        case (state)
            LFWK_LISTEN: begin
                if (fd_rise) begin
                    next_state = correlator_enable_bit ? LFWK_PREAMBLE : LFWK_WAKE;
                end
            end
            LFWK_PREAMBLE: begin
                if (half_stb) begin
                    if (half_chg && (pre_run + 4'h1 >= PRE_MIN_HALVES)) begin
                        next_state = LFWK_PATTERN;
                    end else if (half_cnt + 7'h01 >= PRE_WAIT_HALVES) begin
                        fail = 1'b1;
                    end
                end
            end
            LFWK_PATTERN: begin
                if (half_stb) begin
                    if (pattern_ok(next_rx, pattern, missed_zero_tolerance)) begin
                        next_state = double_pattern_select ? LFWK_PATTERN2 : LFWK_WAKE_DLY;
                    end else if (half_cnt + 7'h01 >= FRAME_MAX_HALVES) begin
                        fail = 1'b1;
                    end
                end
            end
            LFWK_PATTERN2: begin
                if (half_stb && sec_cnt == PAT_LAST) begin
                    if (pattern_ok(next_rx, pattern, missed_zero_tolerance)) begin
                        next_state = LFWK_WAKE_DLY;
                    end else begin
                        fail = 1'b1;
                    end
                end
            end
            LFWK_WAKE_DLY: begin
                if (half_stb && dly_cnt) begin
                    next_state = LFWK_WAKE;
                end
            end
            LFWK_WAKE: begin
                if (terminate_wake || to_expire) begin
                    next_state = LFWK_LISTEN;
                end
            end
            default: begin
                next_state = LFWK_LISTEN;
            end
        endcase
        if (fail) begin
            next_state = LFWK_LISTEN;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= LFWK_LISTEN;
            wake <= 1'b0;
            listening <= 1'b1;
        end else begin
            state <= next_state;
            wake <= (next_state == LFWK_WAKE);
            listening <= (next_state == LFWK_LISTEN);
        end
    end

    // Half-bit history, preamble run and frame length
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_sh <= 16'h0000;
            prev_half <= 1'b0;
            pre_run <= 4'h0;
            half_cnt <= 7'h00;
        end else if (state == LFWK_LISTEN) begin
            rx_sh <= 16'h0000;
            prev_half <= 1'b0;
            pre_run <= 4'h0;
            half_cnt <= 7'h00;
        end else if (half_stb) begin
            rx_sh <= next_rx;
            prev_half <= sample;
            if (half_chg) begin
                pre_run <= (pre_run == 4'hF) ? pre_run : pre_run + 4'h1;
            end else begin
                pre_run <= 4'h0;
            end
            half_cnt <= (half_cnt == 7'h7F) ? half_cnt : half_cnt + 7'h01;
        end
    end

    // Second-pattern and wake-delay counters
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sec_cnt <= 4'h0;
            dly_cnt <= 1'b0;
        end else begin
            if (state != LFWK_PATTERN2) begin
                sec_cnt <= 4'h0;
            end else if (half_stb) begin
                sec_cnt <= sec_cnt + 4'h1;
            end
            if (state != LFWK_WAKE_DLY) begin
                dly_cnt <= 1'b0;
            end else if (half_stb) begin
                dly_cnt <= 1'b1;
            end
        end
    end

    // Automatic termination, counted from the wake rising edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_cnt <= 32'h0000_0000;
            to_steps <= 3'b000;
        end else if (state != LFWK_WAKE) begin
            step_cnt <= 32'h0000_0000;
            to_steps <= 3'b000;
        end else if (step_cnt == 32'(TIMEOUT_STEP_CYCLES - 1)) begin
            step_cnt <= 32'h0000_0000;
            to_steps <= (to_steps == 3'b111) ? to_steps : to_steps + 3'b001;
        end else begin
            step_cnt <= step_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            false_wakeup_count <= `LFWK_FWC_RESET;
        end else if (fail && false_wakeup_count != `LFWK_FWC_MAX) begin
            false_wakeup_count <= false_wakeup_count + 8'h01;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_bypass_wake: assert property (
        (state == LFWK_LISTEN && fd_rise && !correlator_enable_bit) |=> wake)
        else $error("disabled correlator did not wake on frequency detect");
    a_enable_search: assert property (
        (state == LFWK_LISTEN && fd_rise && correlator_enable_bit) |=> !wake ##0
        (state == LFWK_PREAMBLE))
        else $error("enabled correlator skipped preamble search");
    a_count_step: assert property (
        (fail && false_wakeup_count != 8'hFF) |=>
        (false_wakeup_count == $past(false_wakeup_count) + 8'h01) && listening)
        else $error("false wake-up count not stepped on failure");
    a_count_hold: assert property (
        (false_wakeup_count == 8'hFF) |=> (false_wakeup_count == 8'hFF))
        else $error("false wake-up count wrapped");
    a_preamble_min: assert property (
        (state == LFWK_PREAMBLE && next_state == LFWK_PATTERN) |-> (pre_run >= 4'h7))
        else $error("pattern search began before four preamble bits");
    a_tolerance_met: assert property (
        (state == LFWK_PATTERN && next_state != LFWK_PATTERN && !fail) |->
        (zero_misses(next_rx, pattern) <= {3'b000, missed_zero_tolerance}))
        else $error("pattern accepted beyond missed-zero tolerance");
    a_double_needed: assert property (
        (state == LFWK_PATTERN && next_state == LFWK_WAKE_DLY) |-> !double_pattern_select)
        else $error("double mode woke on a single pattern");
    a_wake_delay: assert property (
        (state == LFWK_WAKE_DLY && half_stb && dly_cnt) |=> $rose(wake))
        else $error("wake not raised one bit after pattern");
    a_terminate: assert property (
        (wake && terminate_wake) |=> !wake && listening)
        else $error("terminate command did not end wake");
    a_timeout_off: assert property (
        (state == LFWK_WAKE && tout_code == 3'b000 && !terminate_wake) |=> wake)
        else $error("wake ended with automatic termination disabled");
    a_timeout_end: assert property (
        (wake && to_expire) |=> !wake)
        else $error("wake outlived its timeout");

    c_wake_single: cover property ($rose(wake) && !double_pattern_select);
    c_wake_double: cover property ((state == LFWK_PATTERN2) ##[1:1000] $rose(wake));
    c_fail_count: cover property (fail);
    c_timeout: cover property (wake && to_expire);
endmodule // lfwk_correlator

// ### core/lfwk_cfg.svh
// Constants of the LF wake-up pattern correlator: field positions, counts, timing.
// Assumes a 100 MHz core clock; included by bare name.
// Notes on behaviour
// - Correlation after frequency detection runs only when the correlator enable bit is set.
// - No preamble within 16 bits: back to listening, false wake-up count plus one.
// - Pattern search starts only after at least four preamble bits are seen.
// - Bit time is field code plus one RTC periods, codes 3 to 31.
// - Received half-bits are compared with the 16-half-bit pattern in two bytes.
// - Manchester: low-to-high is symbol 0, high-to-low is symbol 1.
// - Double mode needs the same pattern twice in succession before waking.
// - Two-bit field sets how many missed zeros the match tolerates, zero to three.
// - A matched pattern raises the wake output.
// - A failed detection ends silently and increments the false wake-up count.
// - The host terminate-wake command ends the wake state.
// - Three-bit timeout field: code times 50 ms, up to 350 ms.
// - Timeout counting starts at the wake rising edge, then back to listening.
// - Wake rises one bit period after the pattern's last half-bit.
`ifndef LFWK_CFG_SVH
`define LFWK_CFG_SVH

`define LFWK_BITP_MSB 4
`define LFWK_BITP_LSB 0
`define LFWK_TOUT_MSB 7
`define LFWK_TOUT_LSB 5
`define LFWK_BIT_CODE_MIN 5'h03
`define LFWK_PRE_WAIT_BITS 16
`define LFWK_PRE_MIN_BITS 4
`define LFWK_FRAME_MAX_BITS 40
`define LFWK_PATTERN_HALVES 16
`define LFWK_PATTERN_DEFAULT 8'h96
`define LFWK_FWC_RESET 8'h00
`define LFWK_FWC_MAX 8'hFF
`define LFWK_CLK_PERIOD_NS 10
`define LFWK_TIMEOUT_STEP_MS 50
`define LFWK_TIMEOUT_STEP_CYCLES (`LFWK_TIMEOUT_STEP_MS * 1000000 / `LFWK_CLK_PERIOD_NS)

`endif

// ### core/lfwk_pkg.sv
// Types shared by the LF wake-up pattern correlator.
// Assumes nothing beyond a SystemVerilog compiler.
package lfwk_pkg;
    typedef enum logic [2:0] {
        LFWK_LISTEN,
        LFWK_PREAMBLE,
        LFWK_PATTERN,
        LFWK_PATTERN2,
        LFWK_WAKE_DLY,
        LFWK_WAKE
    } lfwk_state_e;
    typedef logic [4:0] lfwk_code_t;
    typedef logic [15:0] lfwk_halves_t;
endpackage

// ### core/lfwk_bit_timer.sv
// Half-bit strobe generator counted in RTC ticks.
// Assumes rtc_tick is a one-cycle pulse already in the core clock domain.
`timescale 1ns/10ps
`include "lfwk_cfg.svh"
module lfwk_bit_timer
    import lfwk_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic rtc_tick,
    input wire logic resync,
    input wire lfwk_code_t bit_code,
    output logic half_stb
);
    // Phase in half-RTC units; a bit is code+1 ticks, a half-bit is half that
    logic [6:0] acc;
    logic [6:0] bit_len;
    logic [6:0] acc_step;

    assign bit_len = {2'b00, bit_code} + 7'h01;
    assign acc_step = acc + 7'h02;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc <= 7'h00;
        end else if (!run) begin
            acc <= 7'h00;
        end else if (resync) begin
            // Edge seen: land strobes mid half-bit
            acc <= {1'b0, bit_len[6:1]};
        end else if (rtc_tick) begin
            acc <= (acc_step >= bit_len) ? acc_step - bit_len : acc_step;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            half_stb <= 1'b0;
        end else begin
            half_stb <= run && !resync && rtc_tick && (acc_step >= bit_len);
        end
    end

    a_period_range: assert property (@(posedge core_clk) disable iff (sys_rst)
        run |-> (bit_len >= 7'h04 && bit_len <= 7'h20))
        else $error("bit period outside 4..32 RTC periods");
endmodule // lfwk_bit_timer

// ### verification/lfwk_tx_model.sv
// Remote LF transmitter: RTC pin, demodulated carrier and frequency detect.
// Assumes the bench sets half_ticks to match the bit period field in use.
`timescale 1ns/10ps
module lfwk_tx_model (
    output logic rtc_clk_pin,
    output logic lf_data,
    output logic freq_detect
);
    int half_ticks = 2;

    initial begin
        rtc_clk_pin = 1'b0;
        lf_data = 1'b0;
        freq_detect = 1'b0;
    end

    // RTC of 5 MHz, unrelated to the core clock
    always #100 rtc_clk_pin = ~rtc_clk_pin;

    task automatic half(input logic v);
        lf_data = v;
        repeat (half_ticks) @(posedge rtc_clk_pin);
    endtask

    // Burst, preamble bits, then the pattern reps times, carrier off after
    task automatic send(input int pre_bits, input logic [15:0] pat, input int reps);
        @(posedge rtc_clk_pin);
        freq_detect = 1'b1;
        half(1'b1);
        half(1'b1);
        for (int b = 0; b < pre_bits; b++) begin
            half(1'b0);
            half(1'b1);
        end
        for (int r = 0; r < reps; r++) begin
            for (int i = 15; i >= 0; i--) begin
                half(pat[i]);
            end
        end
        lf_data = 1'b0;
        freq_detect = 1'b0;
    endtask
endmodule // lfwk_tx_model

// ### verification/tb_top.sv
// Self-checking bench of the wake-up pattern correlator.
// Assumes the transmitter model drives the async link pins.
`timescale 1ns/10ps
`define CHK(name, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); \
        end \
    end
module tb_top;
    import lfwk_pkg::*;
    localparam int STEP = 20;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic terminate_wake = 1'b0;
    logic correlator_enable_bit = 1'b1;
    logic double_pattern_select = 1'b0;
    logic [1:0] missed_zero_tolerance = 2'h0;
    logic [7:0] wake_pattern_high_byte = 8'h96;
    logic [7:0] wake_pattern_low_byte = 8'h96;
    logic [7:0] bit_period_and_timeout = 8'h03;
    logic rtc_clk_pin;
    logic lf_data;
    logic freq_detect;
    logic wake;
    logic listening;
    logic [7:0] false_wakeup_count;
    logic [7:0] exp_fwc = 8'h00;
    logic [15:0] masks [0:4] = '{16'h0000, 16'h4000, 16'h6000, 16'h6800, 16'h6900};
    int mismatches = 0;
    int check_count = 0;
    int n;

    always #5 core_clk = ~core_clk;

    lfwk_tx_model tx_u (
        .rtc_clk_pin(rtc_clk_pin),
        .lf_data(lf_data),
        .freq_detect(freq_detect)
    );

    lfwk_correlator #(.TIMEOUT_STEP_CYCLES(STEP)) dut_u (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .rtc_clk_pin(rtc_clk_pin),
        .lf_data(lf_data),
        .freq_detect(freq_detect),
        .terminate_wake(terminate_wake),
        .correlator_enable_bit(correlator_enable_bit),
        .double_pattern_select(double_pattern_select),
        .missed_zero_tolerance(missed_zero_tolerance),
        .wake_pattern_high_byte(wake_pattern_high_byte),
        .wake_pattern_low_byte(wake_pattern_low_byte),
        .bit_period_and_timeout(bit_period_and_timeout),
        .wake(wake),
        .listening(listening),
        .false_wakeup_count(false_wakeup_count)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wait_level(input logic lvl, input logic on_wake, input int lim,
                              output int cyc);
        for (cyc = 0; cyc < lim; cyc++) begin
            @(negedge core_clk);
            if (on_wake && wake === lvl) return;
            if (!on_wake && listening === lvl) return;
        end
        mismatches++;
        $display("CHECK FAILED wait_limit expected %0h seen timeout", lvl);
        give_verdict();
    endtask

    task automatic term();
        @(negedge core_clk);
        terminate_wake = 1'b1;
        @(negedge core_clk);
        terminate_wake = 1'b0;
        @(negedge core_clk);
        `CHK("wake_cleared", 1'b0, wake)
        `CHK("listen_back", 1'b1, listening)
    endtask

    task automatic try_frame(input int pre, input logic [15:0] pat, input int reps,
                             input logic exp_wake);
        int c;
        int ht;
        ht = tx_u.half_ticks;
        tx_u.send(pre, pat, reps);
        if (exp_wake) begin
            if (pre > 0) `CHK("wake_early", 1'b0, wake)
            wait_level(1'b1, 1'b1, tx_u.half_ticks * 160 + 100, c);
            // One bit after the last half, 20 core cycles per RTC tick
            if (pre > 0) `CHK("wake_delay", 1'b1, (c >= 20 * ht && c <= 40 * ht + 8))
            `CHK("listen_in_wake", 1'b0, listening)
            term();
        end else begin
            wait_level(1'b1, 1'b0, 12000, c);
            exp_fwc = exp_fwc + 8'h01;
            `CHK("wake_silent", 1'b0, wake)
            `CHK("fwc", exp_fwc, false_wakeup_count)
        end
        repeat (20) @(negedge core_clk);
        $display("test frame pre %0d pattern %h done", pre, pat);
    endtask

    initial begin
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        `CHK("wake_reset", 1'b0, wake)
        `CHK("listen_reset", 1'b1, listening)
        `CHK("fwc_reset", 8'h00, false_wakeup_count)
        $display("test reset done");
        correlator_enable_bit = 1'b0;
        try_frame(0, 16'h0000, 0, 1'b1);
        correlator_enable_bit = 1'b1;
        try_frame(0, 16'h9696, 0, 1'b0);
        try_frame(3, 16'h9696, 1, 1'b0);
        try_frame(4, 16'h9696, 1, 1'b1);
        foreach (masks[i]) begin
            if (i < 3) begin
                bit_period_and_timeout = (i == 0) ? 8'h03 : ((i == 1) ? 8'h07 : 8'h1F);
                tx_u.half_ticks = (int'(bit_period_and_timeout[4:0]) + 1) / 2;
                try_frame(5, 16'h9696, 1, 1'b1);
            end
        end
        bit_period_and_timeout = 8'h03;
        tx_u.half_ticks = 2;
        wake_pattern_low_byte = 8'h3C;
        try_frame(5, 16'h963C, 1, 1'b1);
        try_frame(5, 16'h9696, 1, 1'b0);
        wake_pattern_low_byte = 8'h96;
        for (int t = 0; t < 4; t++) begin
            missed_zero_tolerance = t[1:0];
            try_frame(5, 16'h9696 | masks[t], 1, 1'b1);
            try_frame(5, 16'h9696 | masks[t + 1], 1, 1'b0);
        end
        missed_zero_tolerance = 2'h0;
        double_pattern_select = 1'b1;
        try_frame(5, 16'h9696, 2, 1'b1);
        try_frame(5, 16'h9696, 1, 1'b0);
        double_pattern_select = 1'b0;
        bit_period_and_timeout = 8'h43;
        tx_u.send(5, 16'h9696, 1);
        wait_level(1'b1, 1'b1, 500, n);
        wait_level(1'b0, 1'b1, 200, n);
        `CHK("timeout_len", 1'b1, (n >= 2 * STEP - 1 && n <= 2 * STEP + 3))
        `CHK("listen_after_tout", 1'b1, listening)
        $display("test timeout done");
        bit_period_and_timeout = 8'h03;
        tx_u.send(5, 16'h9696, 1);
        wait_level(1'b1, 1'b1, 500, n);
        repeat (300) @(negedge core_clk);
        `CHK("wake_no_tout", 1'b1, wake)
        term();
        `CHK("fwc_final", exp_fwc, false_wakeup_count)
        $display("test no timeout done");
        give_verdict();
    end
endmodule // tb_top
